/* File: bench/srpg_drive_model.sv */
// model of the motor power stage that receives the step pulses
// assumes the same clock as the generator; arm_i restarts statistics
`timescale 1ns/10ps

module srpg_drive_model (
    input  wire logic        clk_i,      // system clock
    input  wire logic        sys_rst_i,  // async reset, active high
    input  wire logic        step_i,     // step pulse from generator
    input  wire logic        arm_i,      // pulse: new move begins
    output logic      [31:0] count_o,    // steps taken this move
    output logic      [31:0] gap_o,      // cycles between last two steps
    output logic      [31:0] min_gap_o   // shortest gap, fastest rate
);
    logic [31:0] run_reg;  // cycles since the previous step

    // ------------------------------------------------------------------
    // shaft position and rate tracking
    // ------------------------------------------------------------------
    // first step of a move has no gap, so it is not timed
    always_ff @(posedge clk_i or posedge sys_rst_i) begin
        if (sys_rst_i) begin
            count_o   <= 32'h0;
            gap_o     <= 32'h0;
            min_gap_o <= 32'hFFFF_FFFF;
            run_reg   <= 32'h1;
        end else if (arm_i) begin
            // new move: forget what the previous move left behind
            count_o   <= 32'h0;
            gap_o     <= 32'h0;
            min_gap_o <= 32'hFFFF_FFFF;
            run_reg   <= 32'h1;
        end else if (step_i) begin
            count_o <= count_o + 32'h1;
            run_reg <= 32'h1;
            if (count_o != 32'h0) begin
                gap_o <= run_reg;
                if (run_reg < min_gap_o) min_gap_o <= run_reg;
            end
        end else begin
            run_reg <= run_reg + 32'h1;
        end
    end

endmodule : srpg_drive_model

/* File: bench/srpg_profile_gen_props.sv */
// checker for the step rate profile generator top-level ports
// assumes one clock domain; attached to srpg_profile_gen by bind
`timescale 1ns/10ps

module srpg_profile_gen_props (
    input  wire logic       clk_i,      // system clock
    input  wire logic       sys_rst_i,  // async reset, active high
    input  wire logic       start_i,    // move request
    input  wire logic       step_o,     // step pulse
    input  wire logic       busy_o,     // move in progress
    input  wire logic       accel_o,    // rate rising
    input  wire logic       decel_o,    // rate falling
    input  wire logic       done_o,     // move finished
    input  wire logic [1:0] profile_o   // chosen shape
);
    // ------------------------------------------------------------------
    // sequences
    // ------------------------------------------------------------------
    default clocking cb @(posedge clk_i); endclocking
    default disable iff (sys_rst_i);

    // a request counts only while idle
    sequence s_take;
        start_i && !busy_o;
    endsequence
    // move running with a shape chosen
    sequence s_run;
        busy_o && (profile_o != 2'h0);
    endsequence

    // ------------------------------------------------------------------
    // assertions
    // ------------------------------------------------------------------
    chk_start_runs: assert property (s_take |=> s_run)
        else $error("start did not begin a move");
    chk_step_gap: assert property (step_o |=> !step_o [*8])
        else $error("step pulses too close");
    chk_done_one: assert property (done_o |=> !done_o)
        else $error("done longer than one cycle");
    chk_done_idle: assert property (done_o |-> !busy_o && !decel_o)
        else $error("done while still moving");
    chk_busy_fall: assert property ($fell(busy_o) |-> done_o)
        else $error("move ended without done");
    chk_step_inmove: assert property
        (step_o |-> busy_o || $past(busy_o))
        else $error("step outside a move");
    chk_phase_excl: assert property
        ((accel_o || decel_o) |-> busy_o && !(accel_o && decel_o))
        else $error("ramp flags clash");
    chk_decel_hold: assert property
        (decel_o |=> decel_o || !busy_o)
        else $error("decel left before the end");
    chk_prof_hold: assert property
        (busy_o && $past(busy_o) |-> $stable(profile_o))
        else $error("shape changed mid move");
    chk_ramp_first: assert property ($rose(busy_o) |-> !decel_o)
        else $error("move began decelerating");

endmodule : srpg_profile_gen_props

bind srpg_profile_gen srpg_profile_gen_props u_props (
    .clk_i(clk_i), .sys_rst_i(sys_rst_i), .start_i(start_i),
    .step_o(step_o), .busy_o(busy_o), .accel_o(accel_o),
    .decel_o(decel_o), .done_o(done_o), .profile_o(profile_o));

/* File: bench/srpg_profile_gen_tb.sv */
// self-checking bench for the step rate profile generator
// assumes a 20 MHz clock and the power stage model on step_o
`timescale 1ns/10ps
`define CHK(nm, ex, got) begin n_checks++; if ((got) !== (ex)) begin \
    n_mismatch++; $display("Error %s expected %0d seen %0d", nm, ex, got); \
    end end

module srpg_profile_gen_tb;
    localparam longint CLK_HZ = 64'h0131_2D00;  // cycles per second
    logic        clk_i, sys_rst_i, start_i, arm;
    logic [19:0] start_speed_i, prog_speed_i;
    logic [15:0] accel_i, decel_i;
    logic [12:0] jerk_i;
    logic [31:0] total_steps_i, count, gap, min_gap;
    logic        step_o, busy_o, accel_o, decel_o, done_o;
    logic [1:0]  profile_o;
    int          n_mismatch, n_checks, cyc;
    int          acc_cyc, dec_cyc, acc_stp, cru_stp;
    int          r_ac, r_dc, r_as, r_cs;  // per-move results

    srpg_profile_gen dut (.clk_i(clk_i), .sys_rst_i(sys_rst_i),
        .start_i(start_i), .start_speed_i(start_speed_i),
        .prog_speed_i(prog_speed_i), .accel_i(accel_i), .decel_i(decel_i),
        .jerk_i(jerk_i), .total_steps_i(total_steps_i), .step_o(step_o),
        .busy_o(busy_o), .accel_o(accel_o), .decel_o(decel_o),
        .done_o(done_o), .profile_o(profile_o));
    srpg_drive_model u_drv (.clk_i(clk_i), .sys_rst_i(sys_rst_i),
        .step_i(step_o), .arm_i(arm), .count_o(count), .gap_o(gap),
        .min_gap_o(min_gap));

    // ------------------------------------------------------------------
    // clock, phase counters and hang guard
    // ------------------------------------------------------------------
    initial begin
        clk_i = 1'b0;
        forever #25 clk_i = ~clk_i;
    end
    // free-running totals; moves read differences, so no clear race
    always @(posedge clk_i) begin
        cyc++;
        if (accel_o) acc_cyc++;
        if (decel_o) dec_cyc++;
        if (step_o && accel_o) acc_stp++;
        if (step_o && busy_o && !accel_o && !decel_o) cru_stp++;
        if (cyc == 95000) begin
            n_mismatch++;
            end_sim();
        end
    end

    function automatic longint isqrt(input longint x);
        longint r;
        r = 0;
        for (int b = 20; b >= 0; b--)
            if ((r + (64'h1 << b)) ** 2 <= x) r = r + (64'h1 << b);
        return r;
    endfunction : isqrt

    function automatic logic near(input longint g, ex, tol);
        return (g >= ex - tol) && (g <= ex + tol);
    endfunction : near

    // ------------------------------------------------------------------
    // one move; decel equals accel; poke retries start mid move
    // ------------------------------------------------------------------
    task automatic run_move(input logic [19:0] vs, vp,
        input logic [15:0] a, input logic [12:0] j,
        input logic [31:0] n, input bit poke);
        int b0, b1, b2, b3;
        @(negedge clk_i);
        b0 = acc_cyc; b1 = dec_cyc; b2 = acc_stp; b3 = cru_stp;
        @(posedge clk_i);
        {start_speed_i, prog_speed_i, accel_i, decel_i} <= {vs, vp, a, a};
        {jerk_i, total_steps_i, start_i, arm} <= {j, n, 2'h3};
        @(posedge clk_i);
        {start_i, arm} <= 2'h0;
        for (int k = 0; k < 60000 && done_o !== 1'b1; k++) begin
            @(negedge clk_i);
            if (poke && k == 100) begin
                // ignored while busy: count must stay at n
                @(posedge clk_i);
                {start_i, total_steps_i} <= {1'b1, 32'h5};
                @(posedge clk_i);
                start_i <= 1'b0;
            end
        end
        `CHK("done", 1'b1, done_o)
        `CHK("steps", n, count)
        r_ac = acc_cyc - b0; r_dc = dec_cyc - b1;
        r_as = acc_stp - b2; r_cs = cru_stp - b3;
    endtask : run_move

    // ------------------------------------------------------------------
    // scenarios
    // ------------------------------------------------------------------
    task automatic t_trap;
        longint vs, vp, a, ta, da;
        vs = 64'h75300; vp = 64'h7A120; a = 64'hC350;
        ta = (vp - vs) * CLK_HZ / (a * 64'h3E8);
        da = (vp * vp - vs * vs) / (a * 64'h7D0);
        run_move(20'h75300, 20'h7A120, 16'hC350, 13'h0, 32'h1F4, 1'b1);
        `CHK("shape", 2'h1, profile_o)
        `CHK("acc_time", 1'b1, near(r_ac, ta, ta / 50))
        `CHK("dec_time", 1'b1, near(r_dc, ta, ta / 50))
        `CHK("acc_steps", 1'b1, near(r_as, da, 3))
        `CHK("cruise", 1'b1, near(r_cs, 500 - 2 * da, 3))
        `CHK("top_gap", 1'b1, near(min_gap, CLK_HZ / vp, 1))
        `CHK("end_gap", 1'b1, near(gap, CLK_HZ / vs, 1))
    endtask : t_trap

    task automatic t_exact;
        run_move(20'h75300, 20'h7A120, 16'hC350, 13'h0, 32'h188, 1'b0);
        `CHK("shape", 2'h2, profile_o)
        `CHK("cruise", 1'b1, r_cs inside {[1:2]})
    endtask : t_exact

    task automatic t_short;
        longint vs, a, vm, ta;
        vs = 64'h75300; a = 64'hC350;
        vm = isqrt(vs * vs + 64'hC8 * a * 64'h3E8);
        ta = (vm - vs) * CLK_HZ / (a * 64'h3E8);
        run_move(20'h75300, 20'h7A120, 16'hC350, 13'h0, 32'hC8, 1'b0);
        `CHK("shape", 2'h3, profile_o)
        `CHK("cruise", 0, r_cs)
        `CHK("acc_time", 1'b1, near(r_ac, ta, ta * 3 / 100))
    endtask : t_short

    task automatic t_jerk;
        longint vs, vm;
        vs = 64'h186A0;
        vm = isqrt(vs * vs + 64'h3C * 64'hC350 * 64'h3E8);
        run_move(20'h186A0, 20'h7A120, 16'hC350, 13'h1388, 32'h3C, 1'b0);
        // smooth start stays well below the linear peak rate
        `CHK("s_ramp", 1'b1, min_gap > CLK_HZ / vm + 10)
    endtask : t_jerk

    // start speed at the root of the acceleration, short linear move
    task automatic t_smooth;
        run_move(20'h1F9F, 20'h7A120, 16'hFFFF, 13'h0, 32'h8,
                 1'b0);
        `CHK("sm_shape", 2'h3, profile_o)
        `CHK("sm_cruise", 0, r_cs)
    endtask : t_smooth

    // programmed speed below start: the move holds the start speed
    task automatic t_slow;
        run_move(20'h7A120, 20'h75300, 16'hC350, 13'h0, 32'hA,
                 1'b0);
        `CHK("slow_acc", 0, r_ac)
        `CHK("slow_dec", 0, r_dc)
        `CHK("slow_gap", 1'b1, near(min_gap, CLK_HZ / 64'h7A120, 1))
    endtask : t_slow

    task automatic end_sim;
        $display("checks %0d mismatches %0d", n_checks, n_mismatch);
        if (n_mismatch == 0 && n_checks > 0)
            $display("verification passed");
        else
            $display("verification failed");
        $finish;
    endtask : end_sim

    // ------------------------------------------------------------------
    // main sequence
    // ------------------------------------------------------------------
    initial begin
        {sys_rst_i, start_i, arm} = 3'h4;
        {start_speed_i, prog_speed_i, accel_i, decel_i} = 72'h0;
        {jerk_i, total_steps_i} = 45'h0;
        repeat (20) @(posedge clk_i);
        sys_rst_i <= 1'b0;
        @(negedge clk_i);
        `CHK("rst_shape", 2'h0, profile_o)
        `CHK("rst_busy", 1'b0, busy_o)
        t_trap();
        t_exact();
        t_short();
        t_jerk();
        t_smooth();
        t_slow();
        end_sim();
    end

endmodule : srpg_profile_gen_tb

/* File: rtl/srpg_defines.svh */
// constants shared by the step rate profile generator files
// assumes a single 20 MHz clock; included by bare name
`ifndef SRPG_DEFINES_SVH
`define SRPG_DEFINES_SVH

// ----------------------------------------------------------------------
// clock and unit scaling
// ----------------------------------------------------------------------
`define SRPG_CLK_HZ     32'h0131_2D00
`define SRPG_ACC_UNIT   16'h03E8
`define SRPG_VEL_SCALE  16'h4E20
`define SRPG_JERK_DIV   8'h64

// ----------------------------------------------------------------------
// derived thresholds
// ----------------------------------------------------------------------
// phase limit: one step per clk_hz * vel_scale of accumulated rate
`define SRPG_PHASE_LIM  (40'(`SRPG_CLK_HZ) * 40'(`SRPG_VEL_SCALE))
// jerk accumulator wraps once per jerk_div * clk_hz
`define SRPG_JERK_LIM   (32'(`SRPG_JERK_DIV) * `SRPG_CLK_HZ)
// two * acc_unit * vel_scale^2, the decel distance scaling
`define SRPG_DEC_K      (48'h2 * 48'(`SRPG_ACC_UNIT) * \
                         48'(`SRPG_VEL_SCALE) * 48'(`SRPG_VEL_SCALE))
// two * acc_unit, the profile selection scaling
`define SRPG_PROF_K     (16'h2 * `SRPG_ACC_UNIT)

// ----------------------------------------------------------------------
// reset values and the step decrement
// ----------------------------------------------------------------------
`define SRPG_ZERO_VEL   36'h0_0000_0000
`define SRPG_ZERO_PH    40'h00_0000_0000
`define SRPG_ZERO_CNT   32'h0000_0000
`define SRPG_ONE_CNT    32'h0000_0001

`endif

/* File: rtl/srpg_pkg.sv */
// types of the step rate profile generator
// assumes srpg_defines.svh supplies every numeric constant
package srpg_pkg;

    // ------------------------------------------------------------------
    // move sequencer states
    // ------------------------------------------------------------------
    typedef enum logic [1:0] {
        SRPG_IDLE,
        SRPG_ACCEL,
        SRPG_CRUISE,
        SRPG_DECEL
    } srpg_state_type;

    // ------------------------------------------------------------------
    // profile shape chosen at move start
    // ------------------------------------------------------------------
    typedef enum logic [1:0] {
        SRPG_PROF_NONE,
        SRPG_PROF_TRAP,
        SRPG_PROF_TRI_PEAK,
        SRPG_PROF_TRI_SHORT
    } srpg_profile_type;

endpackage : srpg_pkg

/* File: rtl/srpg_profile_gen.sv */
// step rate profile generator: ramps the step rate for one move
// assumes parameters are steady from start_i until done_o
`timescale 1ns/10ps
`include "srpg_defines.svh"

module srpg_profile_gen (
    input  wire logic        clk_i,
    input  wire logic        sys_rst_i,
    input  wire logic        start_i,        // pulse: begin a move
    input  wire logic [19:0] start_speed_i,  // steps per second
    input  wire logic [19:0] prog_speed_i,   // steps per second
    input  wire logic [15:0] accel_i,        // steps per ms per second
    input  wire logic [15:0] decel_i,        // steps per ms per second
    input  wire logic [12:0] jerk_i,         // zero: constant accel
    input  wire logic [31:0] total_steps_i,  // steps in the move
    output logic             step_o,         // one pulse per step
    output logic             busy_o,         // move in progress
    output logic             accel_o,        // rate rising
    output logic             decel_o,        // rate falling
    output logic             done_o,         // pulse: move finished
    output logic [1:0]       profile_o       // shape of the move
);

    // ------------------------------------------------------------------
    // link to the step timer
    // ------------------------------------------------------------------
    srpg_step_if lnk ();

    srpg_step_timer u_timer (
        .clk_i     (clk_i),
        .sys_rst_i (sys_rst_i),
        .lnk       (lnk)
    );

    // ------------------------------------------------------------------
    // state
    // ------------------------------------------------------------------
    srpg_pkg::srpg_state_type   state_reg, state_next;
    srpg_pkg::srpg_profile_type prof_reg, prof_next;
    logic [35:0] vel_reg, vel_next;       // scaled current rate
    logic [15:0] acc_eff_reg, acc_eff_next; // accel now applied
    logic [31:0] jacc_reg, jacc_next;     // jerk fraction accumulator
    logic [35:0] vs_sc_reg, vp_sc_reg;    // scaled speed bounds
    logic [15:0] acc_reg, dec_reg;        // latched ramp parameters
    logic [12:0] jerk_reg;                // latched jerk parameter
    logic        done_reg, done_next;     // move end pulse

    wire idle     = (state_reg == srpg_pkg::SRPG_IDLE);
    wire take     = start_i && idle;

    // ------------------------------------------------------------------
    // profile shape from the incoming parameters
    // ------------------------------------------------------------------
    // ramp distances summed: (vp^2-vs^2)(a+d) / (2*1000*a*d) steps,
    // compared with the total without a divider
    wire [39:0] dv2_in   = 40'(prog_speed_i) * 40'(prog_speed_i) -
                           40'(start_speed_i) * 40'(start_speed_i);
    wire [79:0] ramp_lhs = 80'(dv2_in) *
                           80'(17'(accel_i) + 17'(decel_i));
    wire [79:0] ramp_rhs = 80'(`SRPG_PROF_K) * 80'(accel_i) *
                           80'(decel_i) * 80'(total_steps_i);
    wire        slow_in  = (prog_speed_i <= start_speed_i);

    // ------------------------------------------------------------------
    // deceleration distance for the present rate
    // ------------------------------------------------------------------
    // remaining * 2 * 1000 * d * scale^2 against v^2 - vs^2, both scaled
    wire [71:0] v2_now  = 72'(vel_reg) * 72'(vel_reg);
    wire [71:0] vs2     = 72'(vs_sc_reg) * 72'(vs_sc_reg);
    wire [95:0] dec_avl = 96'(v2_now - vs2);
    wire [95:0] dec_req = 96'(`SRPG_DEC_K) * 96'(dec_reg) *
                          96'(lnk.rem);
    wire        dec_hit = (dec_req <= dec_avl);

    // ------------------------------------------------------------------
    // rate arithmetic; one scaled unit per clock equals 1000 steps/s^2
    // ------------------------------------------------------------------
    wire [35:0] vel_up   = vel_reg + 36'(acc_eff_reg);
    wire [35:0] vel_down = vel_reg - 36'(dec_reg);
    wire        at_top   = (vel_up >= vp_sc_reg);
    wire        at_floor = (vel_reg <= vs_sc_reg + 36'(dec_reg));
    wire [31:0] jacc_sum = jacc_reg + 32'(jerk_reg) * 32'(acc_reg);
    wire        jwrap    = (jacc_sum >= `SRPG_JERK_LIM);
    wire        jerk_on  = (jerk_reg != 13'h0000);

    // ------------------------------------------------------------------
    // sequencer
    // ------------------------------------------------------------------
    always_comb begin
        state_next   = state_reg;
        vel_next     = vel_reg;
        acc_eff_next = acc_eff_reg;
        jacc_next    = jacc_reg;
        prof_next    = prof_reg;
        done_next    = 1'b0;
        unique case (state_reg)
            srpg_pkg::SRPG_IDLE: begin
                if (start_i) begin
                    vel_next     = 36'(start_speed_i) *
                                   36'(`SRPG_VEL_SCALE);
                    // smooth start: acceleration grows from zero
                    acc_eff_next = (jerk_i != 13'h0000) ? 16'h0000
                                                        : accel_i;
                    jacc_next    = `SRPG_ZERO_CNT;
                    state_next   = slow_in ? srpg_pkg::SRPG_CRUISE
                                           : srpg_pkg::SRPG_ACCEL;
                    if (ramp_lhs < ramp_rhs) begin
                        prof_next = srpg_pkg::SRPG_PROF_TRAP;
                    end else if (ramp_lhs == ramp_rhs) begin
                        prof_next = srpg_pkg::SRPG_PROF_TRI_PEAK;
                    end else begin
                        prof_next = srpg_pkg::SRPG_PROF_TRI_SHORT;
                    end
                end
            end
            srpg_pkg::SRPG_ACCEL: begin
                if (lnk.done) begin
                    state_next = srpg_pkg::SRPG_IDLE;
                    done_next  = 1'b1;
                end else if (dec_hit) begin
                    // short move: turn round before the set speed
                    state_next = srpg_pkg::SRPG_DECEL;
                end else if (at_top) begin
                    vel_next   = vp_sc_reg;
                    state_next = srpg_pkg::SRPG_CRUISE;
                end else begin
                    vel_next = vel_up;
                    if (jerk_on) begin
                        // acceleration climbs at jerk/100 * a per second
                        jacc_next = jwrap ? jacc_sum - `SRPG_JERK_LIM
                                          : jacc_sum;
                        if (jwrap && acc_eff_reg < acc_reg) begin
                            acc_eff_next = acc_eff_reg + 16'h0001;
                        end
                    end
                end
            end
            srpg_pkg::SRPG_CRUISE: begin
                if (lnk.done) begin
                    state_next = srpg_pkg::SRPG_IDLE;
                    done_next  = 1'b1;
                end else if (lnk.step && dec_hit) begin
                    // only after a step, so an exact fit gets one pulse
                    state_next = srpg_pkg::SRPG_DECEL;
                end
            end
            srpg_pkg::SRPG_DECEL: begin
                if (lnk.done) begin
                    state_next = srpg_pkg::SRPG_IDLE;
                    done_next  = 1'b1;
                end else begin
                    // never below the starting speed, so the last
                    // steps still arrive
                    vel_next = at_floor ? vs_sc_reg : vel_down;
                end
            end
        endcase
    end

    // ------------------------------------------------------------------
    // sequencer registers
    // ------------------------------------------------------------------
    always_ff @(posedge clk_i or posedge sys_rst_i) begin
        if (sys_rst_i) begin
            state_reg   <= srpg_pkg::SRPG_IDLE;
            prof_reg    <= srpg_pkg::SRPG_PROF_NONE;
            vel_reg     <= `SRPG_ZERO_VEL;
            acc_eff_reg <= 16'h0000;
            jacc_reg    <= `SRPG_ZERO_CNT;
            done_reg    <= 1'b0;
        end else begin
            state_reg   <= state_next;
            prof_reg    <= prof_next;
            vel_reg     <= vel_next;
            acc_eff_reg <= acc_eff_next;
            jacc_reg    <= jacc_next;
            done_reg    <= done_next;
        end
    end

    // ------------------------------------------------------------------
    // parameters latched at move start
    // ------------------------------------------------------------------
    always_ff @(posedge clk_i or posedge sys_rst_i) begin
        if (sys_rst_i) begin
            vs_sc_reg <= `SRPG_ZERO_VEL;
            vp_sc_reg <= `SRPG_ZERO_VEL;
            acc_reg   <= 16'h0000;
            dec_reg   <= 16'h0000;
            jerk_reg  <= 13'h0000;
        end else if (take) begin
            vs_sc_reg <= 36'(start_speed_i) * 36'(`SRPG_VEL_SCALE);
            vp_sc_reg <= 36'(prog_speed_i) * 36'(`SRPG_VEL_SCALE);
            acc_reg   <= accel_i;
            dec_reg   <= decel_i;
            jerk_reg  <= jerk_i;
        end
    end

    // ------------------------------------------------------------------
    // timer drive and outputs
    // ------------------------------------------------------------------
    assign lnk.load  = take;
    assign lnk.total = total_steps_i;
    assign lnk.run   = !idle;
    assign lnk.vel   = vel_reg;

    assign step_o    = lnk.step;
    assign busy_o    = !idle;
    assign accel_o   = (state_reg == srpg_pkg::SRPG_ACCEL);
    assign decel_o   = (state_reg == srpg_pkg::SRPG_DECEL);
    assign done_o    = done_reg;
    assign profile_o = prof_reg;

endmodule : srpg_profile_gen

/* File: rtl/srpg_step_if.sv */
// link between the profile sequencer and its step timer
// assumes both ends share one clock
`timescale 1ns/10ps

interface srpg_step_if;
    logic        load;   // one-cycle pulse: restart count and phase
    logic        run;    // level: accumulate rate into the phase
    logic [35:0] vel;    // rate, steps per second times vel_scale
    logic [31:0] total;  // steps commanded for the move
    logic        step;   // one-cycle step pulse from a flop
    logic [31:0] rem;    // steps still to emit
    logic        done;   // level: remaining count is zero

    modport ctl (output load, run, vel, total, input step, rem, done);
    modport tmr (input load, run, vel, total, output step, rem, done);
endinterface : srpg_step_if

/* File: rtl/srpg_step_timer.sv */
// step timer: phase accumulator and remaining step counter
// assumes the sequencer holds vel steady between edges it controls
`timescale 1ns/10ps
`include "srpg_defines.svh"

module srpg_step_timer (
    input  wire logic clk_i,
    input  wire logic sys_rst_i,
    srpg_step_if.tmr  lnk
);

    // ------------------------------------------------------------------
    // state
    // ------------------------------------------------------------------
    logic [39:0] phase_reg;   // fractional step position
    logic [39:0] phase_next;
    logic [31:0] rem_reg;     // steps left
    logic [31:0] rem_next;
    logic        step_reg;    // step pulse flop
    logic        step_next;

    // ------------------------------------------------------------------
    // decode
    // ------------------------------------------------------------------
    wire  [39:0] phase_sum = phase_reg + 40'(lnk.vel);
    wire         have_left = (rem_reg != `SRPG_ZERO_CNT);
    // a step fires when the phase crosses one full step
    wire         fire      = lnk.run && have_left &&
                             (phase_sum >= `SRPG_PHASE_LIM);

    always_comb begin
        phase_next = phase_reg;
        rem_next   = rem_reg;
        step_next  = 1'b0;
        if (lnk.load) begin
            // fresh move: count from the commanded total
            phase_next = `SRPG_ZERO_PH;
            rem_next   = lnk.total;
        end else if (fire) begin
            // keep the excess so the rate stays exact over many steps
            phase_next = phase_sum - `SRPG_PHASE_LIM;
            rem_next   = rem_reg - `SRPG_ONE_CNT;
            step_next  = 1'b1;
        end else if (lnk.run && have_left) begin
            phase_next = phase_sum;
        end
    end

    // ------------------------------------------------------------------
    // registers
    // ------------------------------------------------------------------
    always_ff @(posedge clk_i or posedge sys_rst_i) begin
        if (sys_rst_i) begin
            phase_reg <= `SRPG_ZERO_PH;
            rem_reg   <= `SRPG_ZERO_CNT;
            step_reg  <= 1'b0;
        end else begin
            phase_reg <= phase_next;
            rem_reg   <= rem_next;
            step_reg  <= step_next;
        end
    end

    assign lnk.step = step_reg;
    assign lnk.rem  = rem_reg;
    // no further pulse once the count reaches zero
    assign lnk.done = !have_left;

endmodule : srpg_step_timer
